// *** shared/exec_pkg.sv ***
// Constants, types and decode helpers for the file-operation and branch execution block
`default_nettype none

package exec_pkg;

   localparam int INSTR_W  = 12;
   localparam int ACC_W    = 8;
   localparam int PC_W     = 11;
   localparam int FADDR_W  = 5;
   localparam int FDEPTH   = 32;
   localparam int LIT_W    = 8;
   localparam int BR_W     = 9;
   localparam int PAGE_W   = 2;

   // Field positions
   localparam int DEST_BIT = 5;

   // Reset values
   localparam logic [ACC_W-1:0] ACC_RESET  = 8'h00;
   localparam logic [PC_W-1:0]  PC_RESET   = 11'h000;
   localparam logic             ZERO_RESET = 1'b0;

   // Counter steps
   localparam logic [PC_W-1:0]  PC_STEP    = 11'h001;
   localparam logic [PC_W-1:0]  PC_SKIP    = 11'h002;
   localparam logic [ACC_W-1:0] INC_STEP   = 8'h01;

   // Instruction timing, clocks from capture to completion
   localparam int OP_CLKS       = 3;
   localparam int OP_EXTRA_CLKS = 1;

   // Opcode masks and match values
   localparam logic [INSTR_W-1:0] MASK_FD   = 12'hfc0;
   localparam logic [INSTR_W-1:0] MASK_F    = 12'hfe0;
   localparam logic [INSTR_W-1:0] MASK_BR   = 12'he00;
   localparam logic [INSTR_W-1:0] MASK_LIT  = 12'hf00;
   localparam logic [INSTR_W-1:0] CODE_INC  = 12'h280;
   localparam logic [INSTR_W-1:0] CODE_INCS = 12'h3c0;
   localparam logic [INSTR_W-1:0] CODE_BR   = 12'ha00;
   localparam logic [INSTR_W-1:0] CODE_ORL  = 12'hd00;
   localparam logic [INSTR_W-1:0] CODE_ORF  = 12'h100;
   localparam logic [INSTR_W-1:0] CODE_STW  = 12'h020;
   localparam logic [INSTR_W-1:0] CODE_MOVE_FILE = 12'h200;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_INCREMENT_FILE,
      OP_INCREMENT_FILE_SKIP_ZERO,
      OP_UNCONDITIONAL_BRANCH,
      OP_OR_LITERAL_TO_ACCUMULATOR,
      OP_OR_ACCUMULATOR_WITH_FILE,
      OP_STORE_ACCUMULATOR_TO_FILE,
      OP_MOVE_FILE
   } op_t;

   function automatic op_t decode_op(input logic [INSTR_W-1:0] instr);
      op_t op;
      op = OP_NONE;
      if ((instr & MASK_FD) == CODE_INC)
         op = OP_INCREMENT_FILE;
      else if ((instr & MASK_FD) == CODE_INCS)
         op = OP_INCREMENT_FILE_SKIP_ZERO;
      else if ((instr & MASK_BR) == CODE_BR)
         op = OP_UNCONDITIONAL_BRANCH;
      else if ((instr & MASK_LIT) == CODE_ORL)
         op = OP_OR_LITERAL_TO_ACCUMULATOR;
      else if ((instr & MASK_FD) == CODE_ORF)
         op = OP_OR_ACCUMULATOR_WITH_FILE;
      else if ((instr & MASK_F) == CODE_STW)
         op = OP_STORE_ACCUMULATOR_TO_FILE;
      else if ((instr & MASK_FD) == CODE_MOVE_FILE)
         op = OP_MOVE_FILE;
      return op;
   endfunction

   function automatic logic [FADDR_W-1:0] file_addr(input logic [INSTR_W-1:0] instr);
      return instr[FADDR_W-1:0];
   endfunction

endpackage

`default_nettype wire

// *** shared/file_port_if.sv ***
// Port between the execution core and its file register memory
`default_nettype none

interface file_port_if
   import exec_pkg::*;
   ();
   logic [FADDR_W-1:0] addr;
   logic               we;
   logic [ACC_W-1:0]   wdata;
   logic [ACC_W-1:0]   rdata;
   logic [FADDR_W-1:0] peek_addr;
   logic [ACC_W-1:0]   peek_data;

   modport core (
      output addr,
      output we,
      output wdata,
      output peek_addr,
      input  rdata,
      input  peek_data
   );

   modport mem (
      input  addr,
      input  we,
      input  wdata,
      input  peek_addr,
      output rdata,
      output peek_data
   );
endinterface

`default_nettype wire

// *** design/file_regs.sv ***
// File register memory, 32 bytes, registered read ports
`default_nettype none

module file_regs
   import exec_pkg::*;
(
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   reset_n_i,
   // Core side
   file_port_if.mem    port
);

   logic [ACC_W-1:0] regs [FDEPTH];

   // Storage
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         for (int i = 0; i < FDEPTH; i++)
            regs[i] <= ACC_RESET;
      end
      else if (port.we)
      begin
         regs[port.addr] <= port.wdata;
      end
   end

   // Registered reads
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         port.rdata     <= ACC_RESET;
         port.peek_data <= ACC_RESET;
      end
      else
      begin
         port.rdata     <= regs[port.addr];
         port.peek_data <= regs[port.peek_addr];
      end
   end

endmodule

`default_nettype wire

// *** design/file_op_branch_exec.sv ***
// Execution core for increment, branch, OR and move operations
`default_nettype none

module file_op_branch_exec
   import exec_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               reset_n_i,
   // Instruction in
   input  wire logic [INSTR_W-1:0] instr_i,
   input  wire logic               instr_valid_i,
   input  wire logic [PAGE_W-1:0]  status_page_i,
   // File register observation
   input  wire logic [FADDR_W-1:0] peek_addr_i,
   output var  logic [ACC_W-1:0]   peek_data_o,
   // Status out
   output logic                    ready_o,
   output logic                    done_o,
   output logic                    skip_o,
   output logic                    zero_o,
   output logic [ACC_W-1:0]        acc_o,
   output logic [PC_W-1:0]         pc_o
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_EXEC,
      ST_FLUSH
   } state_t;

   state_t             state;
   state_t             next_state;
   logic [INSTR_W-1:0] instr;
   logic [PAGE_W-1:0]  page;
   op_t                op;
   logic               dest_file;
   logic [ACC_W-1:0]   next_result;
   logic               write_acc;
   logic               write_file;
   logic               update_zero;
   logic               skip_hit;
   logic               two_cycle;

   file_port_if fport ();

   file_regs u_file_regs (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .port      (fport.mem)
   );

   assign op              = decode_op(instr);
   assign dest_file       = instr[DEST_BIT];
   assign fport.addr      = file_addr(instr);
   assign fport.peek_addr = peek_addr_i;
   assign fport.we        = (state == ST_EXEC) && write_file;
   assign fport.wdata     = next_result;
   assign peek_data_o     = fport.peek_data;

   // Operation datapath
   always_comb
   begin
      next_result = ACC_RESET;
      write_acc   = 1'b0;
      write_file  = 1'b0;
      update_zero = 1'b0;
      skip_hit    = 1'b0;
      two_cycle   = 1'b0;
      case (op)
         OP_INCREMENT_FILE:
         begin
            next_result = fport.rdata + INC_STEP;
            write_acc   = !dest_file;
            write_file  = dest_file;
            update_zero = 1'b1;
         end
         OP_INCREMENT_FILE_SKIP_ZERO:
         begin
            next_result = fport.rdata + INC_STEP;
            write_acc   = !dest_file;
            write_file  = dest_file;
            skip_hit    = (next_result == ACC_RESET);
            two_cycle   = skip_hit;
         end
         OP_UNCONDITIONAL_BRANCH:
         begin
            two_cycle = 1'b1;
         end
         OP_OR_LITERAL_TO_ACCUMULATOR:
         begin
            next_result = acc_o | instr[LIT_W-1:0];
            write_acc   = 1'b1;
            update_zero = 1'b1;
         end
         OP_OR_ACCUMULATOR_WITH_FILE:
         begin
            next_result = acc_o | fport.rdata;
            write_acc   = !dest_file;
            write_file  = dest_file;
            update_zero = 1'b1;
         end
         OP_STORE_ACCUMULATOR_TO_FILE:
         begin
            next_result = acc_o;
            write_file  = 1'b1;
         end
         OP_MOVE_FILE:
         begin
            next_result = fport.rdata;
            write_acc   = !dest_file;
            write_file  = dest_file;
            update_zero = 1'b1;
         end
         default:
         begin
            next_result = ACC_RESET;
         end
      endcase
   end

   // Sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:  if (instr_valid_i) next_state = ST_READ;
         ST_READ:  next_state = ST_EXEC;
         ST_EXEC:  next_state = two_cycle ? ST_FLUSH : ST_IDLE;
         ST_FLUSH: next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Instruction capture
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         instr <= '0;
         page  <= '0;
      end
      else if (state == ST_IDLE && instr_valid_i)
      begin
         instr <= instr_i;
         page  <= status_page_i;
      end
   end

   // Handshake outputs
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ready_o <= 1'b1;
         done_o  <= 1'b0;
         skip_o  <= 1'b0;
      end
      else
      begin
         ready_o <= (next_state == ST_IDLE);
         done_o  <= (state != ST_IDLE) && (next_state == ST_IDLE);
         skip_o  <= (state == ST_FLUSH) && (op == OP_INCREMENT_FILE_SKIP_ZERO);
      end
   end

   // Accumulator and zero flag
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         acc_o  <= ACC_RESET;
         zero_o <= ZERO_RESET;
      end
      else if (state == ST_EXEC)
      begin
         if (write_acc)
            acc_o <= next_result;
         if (update_zero)
            zero_o <= (next_result == ACC_RESET);
      end
   end

   // Program counter
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         pc_o <= PC_RESET;
      else if (state == ST_EXEC)
      begin
         if (op == OP_UNCONDITIONAL_BRANCH)
            pc_o <= {page, instr[BR_W-1:0]};
         else if (skip_hit)
            pc_o <= pc_o + PC_SKIP;
         else
            pc_o <= pc_o + PC_STEP;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   property p_increment_file_acc;
      (state == ST_EXEC && op == OP_INCREMENT_FILE && !dest_file)
         |=> (acc_o == $past(fport.rdata) + INC_STEP) && (zero_o == (acc_o == ACC_RESET));
   endproperty
   a_increment_file_acc: assert property (p_increment_file_acc) else $error("increment result wrong");

   property p_increment_file_skip_zero_skip;
      (state == ST_EXEC && op == OP_INCREMENT_FILE_SKIP_ZERO && fport.rdata == 8'hff)
         |=> (state == ST_FLUSH && !done_o) ##1 (done_o && skip_o);
   endproperty
   a_increment_file_skip_zero_skip: assert property (p_increment_file_skip_zero_skip) else $error("skip not two cycles");

   property p_increment_file_skip_zero_noskip;
      (state == ST_EXEC && op == OP_INCREMENT_FILE_SKIP_ZERO && fport.rdata != 8'hff)
         |=> done_o && !skip_o && $stable(zero_o) && (pc_o == $past(pc_o) + PC_STEP);
   endproperty
   a_increment_file_skip_zero_noskip: assert property (p_increment_file_skip_zero_noskip) else $error("spurious skip");

   property p_branch_pc;
      (state == ST_EXEC && op == OP_UNCONDITIONAL_BRANCH)
         |=> pc_o == {$past(page), $past(instr[BR_W-1:0])};
   endproperty
   a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");

   property p_branch_cycles;
      (state == ST_EXEC && op == OP_UNCONDITIONAL_BRANCH)
         |=> (!done_o && $stable(zero_o)) ##1 (done_o && $stable(zero_o));
   endproperty
   a_branch_cycles: assert property (p_branch_cycles) else $error("branch timing or flag wrong");

   property p_orlit;
      (state == ST_EXEC && op == OP_OR_LITERAL_TO_ACCUMULATOR)
         |=> (acc_o == ($past(acc_o) | $past(instr[LIT_W-1:0]))) && done_o;
   endproperty
   a_orlit: assert property (p_orlit) else $error("literal OR wrong");

   property p_orfile;
      (state == ST_EXEC && op == OP_OR_ACCUMULATOR_WITH_FILE && dest_file)
         |-> fport.we && (fport.wdata == (acc_o | fport.rdata)) ##1 $stable(acc_o);
   endproperty
   a_orfile: assert property (p_orfile) else $error("file OR wrong");

   property p_store;
      (state == ST_EXEC && op == OP_STORE_ACCUMULATOR_TO_FILE)
         |-> fport.we && (fport.wdata == acc_o) ##1 $stable(zero_o) && $stable(acc_o);
   endproperty
   a_store: assert property (p_store) else $error("store wrong or flag touched");

   property p_move_file;
      (state == ST_EXEC && op == OP_MOVE_FILE)
         |=> zero_o == ($past(fport.rdata) == ACC_RESET);
   endproperty
   a_move_file: assert property (p_move_file) else $error("move zero flag wrong");

   property p_zero;
      (state == ST_EXEC && update_zero)
         |=> zero_o == ($past(next_result) == ACC_RESET);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking testbench for the file-operation and branch execution core
`default_nettype none

module tb
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic               clk_i;
   logic               reset_n_i;
   logic [INSTR_W-1:0] instr_i;
   logic               instr_valid_i;
   logic [PAGE_W-1:0]  status_page_i;
   logic [FADDR_W-1:0] peek_addr_i;
   logic [ACC_W-1:0]   peek_data_o;
   logic               ready_o;
   logic               done_o;
   logic               skip_o;
   logic               zero_o;
   logic [ACC_W-1:0]   acc_o;
   logic [PC_W-1:0]    pc_o;
   int                 errors;
   int                 n_compared;
   logic [PC_W-1:0]    pc_exp;

   file_op_branch_exec dut (
      .clk_i         (clk_i),
      .reset_n_i     (reset_n_i),
      .instr_i       (instr_i),
      .instr_valid_i (instr_valid_i),
      .status_page_i (status_page_i),
      .peek_addr_i   (peek_addr_i),
      .peek_data_o   (peek_data_o),
      .ready_o       (ready_o),
      .done_o        (done_o),
      .skip_o        (skip_o),
      .zero_o        (zero_o),
      .acc_o         (acc_o),
      .pc_o          (pc_o)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic conclude();
      if (errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Issue one instruction, compare its length, skip pulse and next counter
   task automatic op(input logic [11:0] ins, input logic [1:0] pg, input logic two_cyc, input logic sk_exp);
      int n;
      @(negedge clk_i);
      check({15'h0000, ready_o}, 16'h0001);
      instr_i = ins;
      status_page_i = pg;
      instr_valid_i = 1'b1;
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      check({15'h0000, ready_o}, 16'h0000);
      n = 1;
      while (done_o !== 1'b1 && n < 50)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 50)
      begin
         errors++;
         conclude();
      end
      if (two_cyc && !sk_exp)
         pc_exp = {pg, ins[8:0]};
      else
         pc_exp = pc_exp + (sk_exp ? PC_SKIP : PC_STEP);
      check(16'(n), 16'(OP_CLKS + (two_cyc ? OP_EXTRA_CLKS : 0)));
      check({15'h0000, skip_o}, {15'h0000, sk_exp});
      check({5'h00, pc_o}, {5'h00, pc_exp});
   endtask

   task automatic peek(input logic [4:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      peek_addr_i = a;
      @(negedge clk_i);
      check({8'h00, peek_data_o}, {8'h00, exp});
   endtask

   task automatic st(input logic [7:0] acc, input logic z);
      check({8'h00, acc_o}, {8'h00, acc});
      check({15'h0000, zero_o}, {15'h0000, z});
   endtask

   task automatic t_reset();
      st(8'h00, 1'b0);
      check({5'h00, pc_o}, 16'h0000);
      check({15'h0000, done_o}, 16'h0000);
      check({15'h0000, skip_o}, 16'h0000);
      peek(5'h05, 8'h00);
   endtask

   task automatic t_or_literal();
      op(12'hd00, 2'b00, 1'b0, 1'b0);
      st(8'h00, 1'b1);
      op(12'hda5, 2'b00, 1'b0, 1'b0);
      st(8'ha5, 1'b0);
   endtask

   task automatic t_store();
      op(12'h023, 2'b00, 1'b0, 1'b0);
      st(8'ha5, 1'b0);
      peek(5'h03, 8'ha5);
      op(12'h03f, 2'b00, 1'b0, 1'b0);
      peek(5'h1f, 8'ha5);
   endtask

   task automatic t_increment();
      op(12'h283, 2'b00, 1'b0, 1'b0);
      st(8'ha6, 1'b0);
      peek(5'h03, 8'ha5);
      op(12'h2a3, 2'b00, 1'b0, 1'b0);
      peek(5'h03, 8'ha6);
   endtask

   task automatic t_skip();
      op(12'hdff, 2'b00, 1'b0, 1'b0);
      op(12'h024, 2'b00, 1'b0, 1'b0);
      op(12'h3e4, 2'b00, 1'b1, 1'b1);
      peek(5'h04, 8'h00);
      op(12'h3c4, 2'b00, 1'b0, 1'b0);
      st(8'h01, 1'b0);
      peek(5'h04, 8'h00);
      op(12'h3e3, 2'b00, 1'b0, 1'b0);
      peek(5'h03, 8'ha7);
   endtask

   task automatic t_move();
      op(12'h204, 2'b00, 1'b0, 1'b0);
      st(8'h00, 1'b1);
      op(12'h025, 2'b00, 1'b0, 1'b0);
      st(8'h00, 1'b1);
      op(12'h223, 2'b00, 1'b0, 1'b0);
      st(8'h00, 1'b0);
      peek(5'h03, 8'ha7);
   endtask

   task automatic t_or_file();
      op(12'h103, 2'b00, 1'b0, 1'b0);
      st(8'ha7, 1'b0);
      op(12'h124, 2'b00, 1'b0, 1'b0);
      peek(5'h04, 8'ha7);
      st(8'ha7, 1'b0);
   endtask

   task automatic t_branch();
      op(12'hbff, 2'b10, 1'b1, 1'b0);
      st(8'ha7, 1'b0);
      op(12'hd00, 2'b00, 1'b0, 1'b0);
      op(12'h225, 2'b00, 1'b0, 1'b0);
      st(8'ha7, 1'b1);
      op(12'ha00, 2'b01, 1'b1, 1'b0);
      st(8'ha7, 1'b1);
   endtask

   initial
   begin
      errors = 0;
      n_compared = 0;
      pc_exp = PC_RESET;
      reset_n_i = 1'b0;
      instr_i = 12'h000;
      instr_valid_i = 1'b0;
      status_page_i = 2'b00;
      peek_addr_i = 5'h00;
      repeat (16) @(posedge clk_i);
      @(negedge clk_i);
      reset_n_i = 1'b1;
      t_reset();
      t_or_literal();
      t_store();
      t_increment();
      t_skip();
      t_move();
      t_or_file();
      t_branch();
      conclude();
   end
endmodule

`default_nettype wire
